// ---- core/dmis_top.sv ----
// APB register file, two transfer engines and the interrupt signalling path
//
// Summary of operation
// - One of four legacy lines A to D signals channel and user interrupts.
// - Message mode allows 1 to 32 vectors; any of the six sources may use any vector below the count.
// - MSI-X offers up to 32 vectors; each of the six sources has its own vector.
// - Run starts descriptor fetch at start address, following next links.
// - Host-to-card engine moves host data to the card side.
// - Card-to-host engine moves card data into host memory.
// - After the last descriptor the engine raises an interrupt.
// - Per-engine status shows pending interrupt, errors and progress.
// - A one-bit output shows whether MSI-X signalling is enabled.
// - A completed-descriptor count register is readable per channel.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "dmis_params.svh"
module dmis_top
  import dmis_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host-to-card descriptor fetch
  output logic h2c_desc_req,
  output logic [31:0] h2c_desc_addr,
  input wire logic h2c_desc_valid,
  input wire dmis_desc_t h2c_desc,
  // Card-to-host descriptor fetch
  output logic c2h_desc_req,
  output logic [31:0] c2h_desc_addr,
  input wire logic c2h_desc_valid,
  input wire dmis_desc_t c2h_desc,
  // Host read data into the card stream
  input wire logic host_rd_valid,
  input wire logic [31:0] host_rd_data,
  output logic host_rd_ready,
  output logic card_out_valid,
  output logic [31:0] card_out_data,
  input wire logic card_out_ready,
  // Card stream into host writes
  input wire logic card_in_valid,
  input wire logic [31:0] card_in_data,
  output logic card_in_ready,
  output logic host_wr_valid,
  output logic [31:0] host_wr_data,
  input wire logic host_wr_ready,
  // User interrupts
  input wire logic [3:0] usr_irq_req,
  output logic [3:0] usr_irq_ack,
  // Host interrupt signalling
  output logic msg_valid,
  output logic [4:0] msg_vector,
  input wire logic msg_ack,
  output logic intx_assert,
  output logic [1:0] intx_line,
  output logic msix_enabled
);
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic nxt_err;
  logic [1:0] blk;
  logic [11:0] off;
  logic wr_go;
  logic msix_en_ff;
  logic [1:0] run_ff;
  logic [31:0] start_ff [2];
  logic [31:0] usr_vec_ff;
  logic [31:0] h2c_mask_ff;
  logic [31:0] c2h_mask_ff;
  logic [31:0] chan_vec_ff;
  dmis_mode_t mode_ff;
  logic [5:0] msi_cnt_ff;
  logic [1:0] irq_clr;
  logic [1:0] busy;
  logic [1:0] done;
  logic [1:0] pend;
  logic [1:0] err;
  logic [31:0] cmpl [2];
  logic [1:0] mask_on;
  logic [3:0] usr_pend;

  assign blk = paddr[13:12];
  assign off = paddr[11:0];
  assign wr_go = psel && penable && pready_ff && pwrite && !pslverr_ff;
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign msix_enabled = msix_en_ff;
  assign mask_on = {c2h_mask_ff[0], h2c_mask_ff[0]};

  always_comb
  begin
    nxt_prdata = 32'h0000_0000;
    nxt_err = 1'b0;
    if (blk == `DMIS_BLK_H2C || blk == `DMIS_BLK_C2H)
    begin
      case (off)
        `DMIS_OFF_CTRL: nxt_prdata = {31'h0000_0000, run_ff[blk[0]]};
        `DMIS_OFF_STATUS:
        begin
          nxt_prdata[`DMIS_ST_BUSY] = busy[blk[0]];
          nxt_prdata[`DMIS_ST_DONE] = done[blk[0]];
          nxt_prdata[`DMIS_ST_IRQ] = pend[blk[0]];
          nxt_prdata[`DMIS_ST_RUN] = run_ff[blk[0]];
          nxt_prdata[`DMIS_ST_ERR] = err[blk[0]];
        end
        `DMIS_OFF_CMPL: nxt_prdata = cmpl[blk[0]];
        `DMIS_OFF_DESC: nxt_prdata = start_ff[blk[0]];
        default: nxt_err = 1'b1;
      endcase
    end
    else if (blk == `DMIS_BLK_IRQ && paddr[15:14] == 2'h0)
    begin
      case (off)
        `DMIS_OFF_USR_VEC: nxt_prdata = usr_vec_ff;
        `DMIS_OFF_H2C_MASK: nxt_prdata = h2c_mask_ff;
        `DMIS_OFF_C2H_MASK: nxt_prdata = c2h_mask_ff;
        `DMIS_OFF_CHAN_VEC: nxt_prdata = chan_vec_ff;
        `DMIS_OFF_MODE: nxt_prdata = {22'h00_0000, msi_cnt_ff, 2'h0, mode_ff};
        `DMIS_OFF_USR_PEND: nxt_prdata = {28'h000_0000, usr_pend};
        default: nxt_err = 1'b1;
      endcase
    end
    else
      nxt_err = 1'b1;
    if (paddr[15:14] != 2'h0 || paddr[1:0] != 2'h0)
      nxt_err = 1'b1;
  end

  // Answer in the first access cycle; read data is captured in setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= `DMIS_RST_WORD;
    end
    else
    begin
      pready_ff <= psel && !penable && !pready_ff;
      pslverr_ff <= psel && !penable && !pready_ff && nxt_err;
      if (psel && !penable && !pwrite)
        prdata_ff <= nxt_prdata;
    end
  end

  // Engine control; start address must be in place before run rises
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_ff <= 2'h0;
      start_ff[0] <= `DMIS_RST_WORD;
      start_ff[1] <= `DMIS_RST_WORD;
    end
    else if (wr_go && blk != `DMIS_BLK_IRQ)
    begin
      if (off == `DMIS_OFF_CTRL)
        run_ff[blk[0]] <= pwdata[0];
      if (off == `DMIS_OFF_DESC)
        start_ff[blk[0]] <= pwdata;
    end
  end

  // Write one to the status pending bit to clear it
  always_comb
  begin
    irq_clr = 2'h0;
    if (wr_go && blk != `DMIS_BLK_IRQ && off == `DMIS_OFF_STATUS)
      irq_clr[blk[0]] = pwdata[`DMIS_ST_IRQ];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      usr_vec_ff <= `DMIS_RST_WORD;
      h2c_mask_ff <= `DMIS_RST_WORD;
      c2h_mask_ff <= `DMIS_RST_WORD;
      chan_vec_ff <= `DMIS_RST_WORD;
      mode_ff <= MODE_LEGACY;
      msi_cnt_ff <= `DMIS_RST_MSI_CNT;
    end
    else if (wr_go && blk == `DMIS_BLK_IRQ)
    begin
      case (off)
        `DMIS_OFF_USR_VEC: usr_vec_ff <= pwdata;
        `DMIS_OFF_H2C_MASK: h2c_mask_ff <= pwdata;
        `DMIS_OFF_C2H_MASK: c2h_mask_ff <= pwdata;
        `DMIS_OFF_CHAN_VEC: chan_vec_ff <= pwdata;
        `DMIS_OFF_MODE:
        begin
          mode_ff <= dmis_mode_t'(pwdata[1:0]);
          if (pwdata[9:4] != 6'h00 && pwdata[9:4] <= `DMIS_MAX_VEC)
            msi_cnt_ff <= pwdata[9:4];
        end
        default: mode_ff <= mode_ff;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      msix_en_ff <= 1'b0;
    else
      msix_en_ff <= (mode_ff == MODE_MSIX);
  end

  dmis_channel u_h2c (
    .pclk(pclk),
    .presetn(presetn),
    .run(run_ff[0]),
    .start_addr(start_ff[0]),
    .irq_clr(irq_clr[0]),
    .busy(busy[0]),
    .done_ff(done[0]),
    .irq_pend_ff(pend[0]),
    .err_ff(err[0]),
    .cmpl_cnt_ff(cmpl[0]),
    .desc_req_ff(h2c_desc_req),
    .desc_addr_ff(h2c_desc_addr),
    .desc_valid(h2c_desc_valid),
    .desc(h2c_desc),
    .src_valid(host_rd_valid),
    .src_data(host_rd_data),
    .src_ready_ff(host_rd_ready),
    .dst_valid_ff(card_out_valid),
    .dst_data_ff(card_out_data),
    .dst_ready(card_out_ready)
  );

  dmis_channel u_c2h (
    .pclk(pclk),
    .presetn(presetn),
    .run(run_ff[1]),
    .start_addr(start_ff[1]),
    .irq_clr(irq_clr[1]),
    .busy(busy[1]),
    .done_ff(done[1]),
    .irq_pend_ff(pend[1]),
    .err_ff(err[1]),
    .cmpl_cnt_ff(cmpl[1]),
    .desc_req_ff(c2h_desc_req),
    .desc_addr_ff(c2h_desc_addr),
    .desc_valid(c2h_desc_valid),
    .desc(c2h_desc),
    .src_valid(card_in_valid),
    .src_data(card_in_data),
    .src_ready_ff(card_in_ready),
    .dst_valid_ff(host_wr_valid),
    .dst_data_ff(host_wr_data),
    .dst_ready(host_wr_ready)
  );

  // Masked channels still record pending status but never reach the host
  dmis_irq u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .mode(mode_ff),
    .msi_cnt(msi_cnt_ff),
    .chan_vec({chan_vec_ff[12:8], chan_vec_ff[4:0]}),
    .usr_vec({usr_vec_ff[28:24], usr_vec_ff[20:16], usr_vec_ff[12:8], usr_vec_ff[4:0]}),
    .chan_ev(done & mask_on),
    .chan_pend(pend & mask_on),
    .usr_irq_req(usr_irq_req),
    .usr_irq_ack_ff(usr_irq_ack),
    .usr_pend_ff(usr_pend),
    .msg_valid_ff(msg_valid),
    .msg_vector_ff(msg_vector),
    .msg_ack(msg_ack),
    .intx_assert_ff(intx_assert),
    .intx_line_ff(intx_line)
  );

  sequence s_apb_setup;
    psel && !penable && !pready_ff;
  endsequence

  a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    s_apb_setup |=> pready_ff ##1 !pready_ff) else $error("APB answer not one cycle");
  a_msix_flag: assert property (@(posedge pclk) disable iff (!presetn)
    mode_ff == MODE_MSIX [*2] |-> msix_enabled) else $error("MSI-X flag low");
  a_run_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_go && off == `DMIS_OFF_CTRL && blk == `DMIS_BLK_H2C |=> run_ff[0] == $past(pwdata[0]))
    else $error("Run bit not written");
endmodule : dmis_top

// ---- core/dmis_params.svh ----
// Register map, field positions, reset values and codes of the interrupt signalling block
`ifndef DMIS_PARAMS_SVH
`define DMIS_PARAMS_SVH
`define DMIS_BLK_H2C 2'h0
`define DMIS_BLK_C2H 2'h1
`define DMIS_BLK_IRQ 2'h2
`define DMIS_OFF_CTRL 12'h004
`define DMIS_OFF_STATUS 12'h040
`define DMIS_OFF_CMPL 12'h048
`define DMIS_OFF_DESC 12'h080
`define DMIS_OFF_USR_VEC 12'h080
`define DMIS_OFF_H2C_MASK 12'h090
`define DMIS_OFF_C2H_MASK 12'h094
`define DMIS_OFF_CHAN_VEC 12'h0a0
`define DMIS_OFF_MODE 12'h0c0
`define DMIS_OFF_USR_PEND 12'h0c4
`define DMIS_ST_BUSY 0
`define DMIS_ST_DONE 1
`define DMIS_ST_IRQ 5
`define DMIS_ST_RUN 6
`define DMIS_ST_ERR 8
`define DMIS_RST_WORD 32'h0000_0000
`define DMIS_RST_MSI_CNT 6'h01
`define DMIS_MAX_VEC 6'h20
`define DMIS_LEG_A 2'h0
`endif

// ---- core/dmis_pkg.sv ----
// Types shared by the interrupt signalling block
package dmis_pkg;
  typedef enum logic [1:0] {
    CH_IDLE = 2'b00,
    CH_FETCH = 2'b01,
    CH_MOVE = 2'b10,
    CH_DONE = 2'b11
  } dmis_ch_state_t;
  typedef enum logic [1:0] {
    MODE_LEGACY = 2'b00,
    MODE_MSI = 2'b01,
    MODE_MSIX = 2'b10,
    MODE_RSVD = 2'b11
  } dmis_mode_t;
  typedef struct packed {
    logic err;
    logic last;
    logic [31:0] next;
    logic [15:0] len;
  } dmis_desc_t;
endpackage : dmis_pkg

// ---- core/dmis_channel.sv ----
// One descriptor driven transfer engine, used for both directions
`timescale 1ns/1ps
`include "dmis_params.svh"
module dmis_channel
  import dmis_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control and status
  input wire logic run,
  input wire logic [31:0] start_addr,
  input wire logic irq_clr,
  output logic busy,
  output logic done_ff,
  output logic irq_pend_ff,
  output logic err_ff,
  output logic [31:0] cmpl_cnt_ff,
  // Descriptor fetch
  output logic desc_req_ff,
  output logic [31:0] desc_addr_ff,
  input wire logic desc_valid,
  input wire dmis_desc_t desc,
  // Source and destination beats
  input wire logic src_valid,
  input wire logic [31:0] src_data,
  output logic src_ready_ff,
  output logic dst_valid_ff,
  output logic [31:0] dst_data_ff,
  input wire logic dst_ready
);
  dmis_ch_state_t state_ff;
  logic run_ff;
  logic last_ff;
  logic [15:0] beats_ff;
  logic accept;

  assign accept = src_valid & src_ready_ff;
  assign busy = (state_ff != CH_IDLE) | dst_valid_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= CH_IDLE;
      run_ff <= 1'b0;
      last_ff <= 1'b0;
      beats_ff <= 16'h0000;
      desc_req_ff <= 1'b0;
      desc_addr_ff <= `DMIS_RST_WORD;
      cmpl_cnt_ff <= `DMIS_RST_WORD;
      err_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      run_ff <= run;
      done_ff <= 1'b0;
      if (accept)
        beats_ff <= beats_ff - 16'h0001;
      case (state_ff)
        CH_IDLE:
        begin
          if (run && !run_ff)
          begin
            state_ff <= CH_FETCH;
            desc_req_ff <= 1'b1;
            desc_addr_ff <= start_addr;
            cmpl_cnt_ff <= `DMIS_RST_WORD;
            err_ff <= 1'b0;
          end
        end
        CH_FETCH:
        begin
          if (!run)
          begin
            state_ff <= CH_IDLE;
            desc_req_ff <= 1'b0;
          end
          else if (desc_valid)
          begin
            desc_req_ff <= 1'b0;
            if (desc.err)
            begin
              err_ff <= 1'b1;
              state_ff <= CH_IDLE;
            end
            else
            begin
              beats_ff <= desc.len;
              last_ff <= desc.last;
              desc_addr_ff <= desc.next;
              state_ff <= CH_MOVE;
            end
          end
        end
        CH_MOVE:
        begin
          if (!run)
            state_ff <= CH_IDLE;
          else if (beats_ff == 16'h0000 && !dst_valid_ff)
          begin
            cmpl_cnt_ff <= cmpl_cnt_ff + 32'h0000_0001;
            if (last_ff)
              state_ff <= CH_DONE;
            else
            begin
              state_ff <= CH_FETCH;
              desc_req_ff <= 1'b1;
            end
          end
        end
        CH_DONE:
        begin
          done_ff <= 1'b1;
          state_ff <= CH_IDLE;
        end
        default: state_ff <= CH_IDLE;
      endcase
    end
  end

  // One holding stage; at most one beat every three cycles is traded for outputs straight from flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      src_ready_ff <= 1'b0;
      dst_valid_ff <= 1'b0;
      dst_data_ff <= `DMIS_RST_WORD;
    end
    else
    begin
      src_ready_ff <= (state_ff == CH_MOVE) && run && (beats_ff != 16'h0000) && !accept &&
                      (src_ready_ff || !dst_valid_ff);
      if (accept)
      begin
        dst_valid_ff <= 1'b1;
        dst_data_ff <= src_data;
      end
      else if (dst_ready)
        dst_valid_ff <= 1'b0;
    end
  end

  // Completion sets the pending flag; a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_pend_ff <= 1'b0;
    else if (done_ff)
      irq_pend_ff <= 1'b1;
    else if (irq_clr)
      irq_pend_ff <= 1'b0;
  end

  a_done_sets_pend: assert property (@(posedge pclk) disable iff (!presetn)
    done_ff |=> irq_pend_ff) else $error("Done without pending flag");
  a_fetch_hold: assert property (@(posedge pclk) disable iff (!presetn)
    desc_req_ff && !desc_valid && run && state_ff == CH_FETCH |=> desc_req_ff && $stable(desc_addr_ff))
    else $error("Fetch request dropped early");
  a_beat_passes: assert property (@(posedge pclk) disable iff (!presetn)
    accept |=> dst_valid_ff && dst_data_ff == $past(src_data) && !src_ready_ff)
    else $error("Beat not forwarded");
endmodule : dmis_channel

// ---- core/dmis_irq.sv ----
// Turns channel and user events into legacy or message interrupts
`timescale 1ns/1ps
`include "dmis_params.svh"
module dmis_irq
  import dmis_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Configuration
  input wire dmis_mode_t mode,
  input wire logic [5:0] msi_cnt,
  input wire logic [9:0] chan_vec,
  input wire logic [19:0] usr_vec,
  // Sources
  input wire logic [1:0] chan_ev,
  input wire logic [1:0] chan_pend,
  input wire logic [3:0] usr_irq_req,
  output logic [3:0] usr_irq_ack_ff,
  output logic [3:0] usr_pend_ff,
  // Host side
  output logic msg_valid_ff,
  output logic [4:0] msg_vector_ff,
  input wire logic msg_ack,
  output logic intx_assert_ff,
  output logic [1:0] intx_line_ff
);
  logic [5:0] need_ff;
  logic [5:0] set;
  logic [5:0] clr;
  logic [2:0] src_ff;
  logic [2:0] pick;
  logic found;
  logic [4:0] raw_vec;
  logic [29:0] vecs;

  assign vecs = {usr_vec, chan_vec};
  assign set = {usr_irq_req & ~usr_pend_ff, chan_ev};

  always_comb
  begin
    pick = 3'h0;
    found = 1'b0;
    for (int i = 5; i >= 0; i--)
      if (need_ff[i])
      begin
        pick = 3'(i);
        found = 1'b1;
      end
    raw_vec = vecs[pick*5 +: 5];
    clr = 6'h00;
    if (mode == MODE_LEGACY)
      clr = need_ff;
    else if (msg_valid_ff && msg_ack)
      clr[src_ff] = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      need_ff <= 6'h00;
      usr_pend_ff <= 4'h0;
      usr_irq_ack_ff <= 4'h0;
    end
    else
    begin
      need_ff <= (need_ff & ~clr) | set;
      usr_pend_ff <= usr_irq_req;
      usr_irq_ack_ff <= clr[5:2];
    end
  end

  // In MSI mode, vectors at or above the granted count fall back to vector zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      msg_valid_ff <= 1'b0;
      msg_vector_ff <= 5'h00;
      src_ff <= 3'h0;
    end
    else if (msg_valid_ff)
    begin
      if (msg_ack)
        msg_valid_ff <= 1'b0;
    end
    else if (found && mode != MODE_LEGACY && mode != MODE_RSVD)
    begin
      msg_valid_ff <= 1'b1;
      src_ff <= pick;
      if (mode == MODE_MSI && {1'b0, raw_vec} >= msi_cnt)
        msg_vector_ff <= 5'h00;
      else
        msg_vector_ff <= raw_vec;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      intx_assert_ff <= 1'b0;
      intx_line_ff <= `DMIS_LEG_A;
    end
    else
    begin
      intx_assert_ff <= (mode == MODE_LEGACY) && ((|chan_pend) || (|usr_irq_req));
      intx_line_ff <= chan_vec[1:0];
    end
  end

  a_msg_held: assert property (@(posedge pclk) disable iff (!presetn)
    msg_valid_ff && !msg_ack |=> msg_valid_ff && $stable(msg_vector_ff))
    else $error("Message dropped before acknowledge");
  a_usr_ack_once: assert property (@(posedge pclk) disable iff (!presetn)
    usr_irq_ack_ff[0] |=> !usr_irq_ack_ff[0]) else $error("Repeated user acknowledge");
  a_pend_follows: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(usr_irq_req[1]) |=> !usr_pend_ff[1]) else $error("Pending not cleared");
endmodule : dmis_irq

// ---- verif/dmis_far_model.sv ----
// Far-side model: host memory, card streams and message acceptor
`timescale 1ns/1ps
module dmis_far_model
  import dmis_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Descriptor answers; while send_err is high every host-to-card descriptor is marked bad
  input wire logic send_err,
  input wire logic h2c_desc_req,
  output logic h2c_desc_valid,
  output dmis_desc_t h2c_desc,
  input wire logic c2h_desc_req,
  output logic c2h_desc_valid,
  output dmis_desc_t c2h_desc,
  // Sources, advanced only on a taken beat
  input wire logic rd_take,
  output logic [31:0] rd_data,
  input wire logic in_take,
  output logic [31:0] in_data,
  output logic src_valid,
  // Sinks and message acceptor
  output logic sink_ready,
  input wire logic msg_valid,
  output logic msg_ack
);
  localparam dmis_desc_t ONE = '{err: 1'b0, last: 1'b1, next: 32'h0, len: 16'h0002};
  logic [3:0] tick_ff;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      tick_ff <= 4'h0;
      h2c_desc_valid <= 1'b0;
      c2h_desc_valid <= 1'b0;
      h2c_desc <= ~ONE;
      c2h_desc <= ~ONE;
      rd_data <= 32'h0;
      in_data <= 32'h0;
      src_valid <= 1'b0;
      sink_ready <= 1'b0;
      msg_ack <= 1'b0;
    end
    else
    begin
      tick_ff <= tick_ff + 4'h1;
      // Answer late so the fetch request has to stand; idle bus shows garbage
      h2c_desc_valid <= h2c_desc_req && !h2c_desc_valid && tick_ff[0];
      c2h_desc_valid <= c2h_desc_req && !c2h_desc_valid && tick_ff[0];
      h2c_desc <= (h2c_desc_req && !h2c_desc_valid && tick_ff[0]) ?
                  {send_err, ONE[48:0]} : ~ONE;
      c2h_desc <= (c2h_desc_req && !c2h_desc_valid && tick_ff[0]) ? ONE : ~ONE;
      src_valid <= 1'b1;
      if (rd_take)
        rd_data <= rd_data + 32'h1;
      if (in_take)
        in_data <= in_data + 32'h1;
      // Sinks stall half the time to exercise back-pressure
      sink_ready <= tick_ff[1];
      msg_ack <= msg_valid && !msg_ack && tick_ff[2];
    end
endmodule : dmis_far_model

// ---- verif/tb.sv ----
// Self-checking bench for the interrupt signalling block
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; $display("BAD %0t got %h exp %h", $time, (a), (e)); end end
`define WAITHI(c) begin for (n = 0; n < 400 && (c) !== 1'b1; n++) @(posedge pclk); if (n == 400) begin errors++; summarize(); end end
module tb
  import dmis_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, rd_data, in_data, card_out_data, host_wr_data;
  logic pready, pslverr, slv, h2c_desc_req, c2h_desc_req, h2c_desc_valid, c2h_desc_valid;
  logic [31:0] h2c_desc_addr, c2h_desc_addr, h2c_exp = 32'h0, c2h_exp = 32'h0;
  dmis_desc_t h2c_desc, c2h_desc;
  logic src_valid, host_rd_ready, card_in_ready, sink_ready, card_out_valid, host_wr_valid;
  logic [3:0] usr_irq_req = 4'h0, usr_irq_ack;
  logic msg_valid, msg_ack, intx_assert, msix_enabled, send_err = 1'b0;
  logic [4:0] msg_vector;
  logic [1:0] intx_line;
  int errors = 0, checks = 0, n;
  always #12.5 pclk = ~pclk;
  dmis_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .h2c_desc_req(h2c_desc_req), .h2c_desc_addr(h2c_desc_addr),
    .h2c_desc_valid(h2c_desc_valid), .h2c_desc(h2c_desc), .c2h_desc_req(c2h_desc_req),
    .c2h_desc_addr(c2h_desc_addr), .c2h_desc_valid(c2h_desc_valid), .c2h_desc(c2h_desc),
    .host_rd_valid(src_valid), .host_rd_data(rd_data), .host_rd_ready(host_rd_ready),
    .card_out_valid(card_out_valid), .card_out_data(card_out_data),
    .card_out_ready(sink_ready), .card_in_valid(src_valid), .card_in_data(in_data),
    .card_in_ready(card_in_ready), .host_wr_valid(host_wr_valid),
    .host_wr_data(host_wr_data), .host_wr_ready(sink_ready), .usr_irq_req(usr_irq_req),
    .usr_irq_ack(usr_irq_ack), .msg_valid(msg_valid), .msg_vector(msg_vector),
    .msg_ack(msg_ack), .intx_assert(intx_assert), .intx_line(intx_line),
    .msix_enabled(msix_enabled));
  dmis_far_model far (.pclk(pclk), .presetn(presetn), .h2c_desc_req(h2c_desc_req),
    .h2c_desc_valid(h2c_desc_valid), .h2c_desc(h2c_desc), .c2h_desc_req(c2h_desc_req),
    .c2h_desc_valid(c2h_desc_valid), .c2h_desc(c2h_desc), .rd_take(host_rd_ready),
    .rd_data(rd_data), .in_take(card_in_ready), .in_data(in_data), .src_valid(src_valid),
    .sink_ready(sink_ready), .msg_valid(msg_valid), .msg_ack(msg_ack), .send_err(send_err));
  // Streams must arrive in source order, none lost or repeated
  always @(posedge pclk)
  begin
    if (card_out_valid && sink_ready)
    begin
      `CHK(card_out_data, h2c_exp)
      h2c_exp = h2c_exp + 32'h1;
    end
    if (host_wr_valid && sink_ready)
    begin
      `CHK(host_wr_data, c2h_exp)
      c2h_exp = c2h_exp + 32'h1;
    end
  end
  task automatic summarize();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    `WAITHI(pready)
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic run_ch(input logic [15:0] b, input logic [31:0] sa);
    apb(1'b1, b | 16'h0080, sa);
    apb(1'b1, b | 16'h0004, 32'h1);
    `WAITHI(b[12] ? c2h_desc_req : h2c_desc_req)
    `CHK(b[12] ? c2h_desc_addr : h2c_desc_addr, sa)
  endtask : run_ch
  task automatic finish_ch(input logic [15:0] b);
    apb(1'b0, b | 16'h0040, 32'h0);
    `CHK(rd[5], 1'b1)
    `CHK(rd[8], 1'b0)
    apb(1'b0, b | 16'h0048, 32'h0);
    `CHK(rd, 32'h1)
    apb(1'b1, b | 16'h0040, 32'h20);
    apb(1'b1, b | 16'h0004, 32'h0);
  endtask : finish_ch
  task automatic t_regs();
    apb(1'b0, 16'h20c0, 32'h0);
    `CHK(rd[9:4], 6'h01)
    apb(1'b0, 16'h0048, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b1, 16'h3000, 32'h1);
    `CHK(slv, 1'b1)
  endtask : t_regs
  // A bad descriptor must stop the engine with the error bit and no completion
  task automatic t_error();
    send_err <= 1'b1;
    run_ch(16'h0000, 32'h0000_4000);
    repeat (4) @(posedge pclk);
    apb(1'b0, 16'h0040, 32'h0);
    `CHK(rd[8], 1'b1)
    `CHK(rd[5], 1'b0)
    apb(1'b0, 16'h0048, 32'h0);
    `CHK(rd, 32'h0)
    send_err <= 1'b0;
    apb(1'b1, 16'h0004, 32'h0);
  endtask : t_error
  task automatic t_legacy();
    logic [15:0] b;
    apb(1'b1, 16'h2090, 32'h1);
    apb(1'b1, 16'h2094, 32'h1);
    for (int c = 0; c < 4; c++)
    begin
      b = c[0] ? 16'h1000 : 16'h0000;
      apb(1'b1, 16'h2080, {4{6'h00, c[1:0]}});
      apb(1'b1, 16'h20a0, {16'h0, 6'h00, c[1:0], 6'h00, c[1:0]});
      run_ch(b, {22'h0, c[1:0], 8'h40});
      `WAITHI(intx_assert)
      `CHK(intx_line, c[1:0])
      finish_ch(b);
      `CHK(intx_assert, 1'b0)
    end
    // Keeping the request high must keep the source pending
    usr_irq_req <= 4'h2;
    `WAITHI(usr_irq_ack[1])
    `CHK(intx_assert, 1'b1)
    apb(1'b0, 16'h20c4, 32'h0);
    `CHK(rd[3:0], 4'h2)
    usr_irq_req <= 4'h0;
    apb(1'b0, 16'h20c4, 32'h0);
    `CHK(rd[3:0], 4'h0)
  endtask : t_legacy
  task automatic t_message();
    apb(1'b1, 16'h20a0, 32'h0000_0905);
    apb(1'b1, 16'h2080, 32'h0000_0011);
    apb(1'b1, 16'h20c0, 32'h0000_0041);
    `CHK(msix_enabled, 1'b0)
    // Vector 9 is beyond a count of 4, so vector 0 goes out
    run_ch(16'h1000, 32'h0000_2000);
    `WAITHI(msg_valid)
    `CHK(msg_vector, 5'h00)
    finish_ch(16'h1000);
    apb(1'b1, 16'h20c0, 32'h0000_0012);
    // The flag follows the mode register one cycle later
    repeat (2) @(posedge pclk);
    `CHK(msix_enabled, 1'b1)
    run_ch(16'h1000, 32'h0000_3000);
    `WAITHI(msg_valid)
    `CHK(msg_vector, 5'h09)
    finish_ch(16'h1000);
    usr_irq_req <= 4'h1;
    `WAITHI(msg_valid)
    `CHK(msg_vector, 5'h11)
    `WAITHI(usr_irq_ack[0])
    usr_irq_req <= 4'h0;
  endtask : t_message
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_legacy();
    t_message();
    t_error();
    repeat (10) @(posedge pclk);
    summarize();
  end
endmodule : tb
